// file: hdl/weigh_command_handshake.sv
// command translation and toggle handshake
// Behaviour
// - decode idle, weigh, zero and reset codes
// - codes 07 to 0A select tare family
// - codes 06 and 0B start repeating weighing
// - 0C adjust, 0D check, 0E not executable
// - codes 0F to 13 cover trigger mode
// - 14 format inquiry, 15/16 control mode
// - 17-1E reserved, 1F passes free string
// - unit string encoded by fixed table
// - unknown unit gives first printable character
// - adjust and check forward several replies
// - handshake identical in basic and extended layout
// - first toggle raise copies into response toggle
// - valid when toggles equal and both valid
// - basic layout returns status, unit, weight
// - extended adds raw string; 1F only raw
// - on send copy toggle, clear answer valid
// - answer valid only with matching reply data
// - echoed code reports code of reply
// - weight as big endian single float
`timescale 1ns/1ps
module weigh_command_handshake
#(
  parameter int DEC_MAX = 6 // most decimals the float converter serves
)
(
  input  wire logic                                     CLOCK_I,
  input  wire logic                                     RESET_N_I,
  input  wire logic                                     EXT_MODE_I,
  input  wire logic                                     QUERY_VALID_FLAG_I,
  input  wire logic                                     QUERY_TOGGLE_FLAG_I,
  input  wire logic [4:0]                               COMMAND_CODE_I,
  input  wire logic [wch_pkg::QUERY_BYTES-1:0][7:0]     QUERY_TEXT_I,
  input  wire logic                                     SENSOR_REQ_READY_I,
  input  wire logic                                     REPLY_VALID_I,
  input  wire wch_pkg::wch_reply_t                      REPLY_I,
  output logic                                          RESPONSE_TOGGLE_FLAG_O,
  output logic                                          ANSWER_VALID_FLAG_O,
  output logic [4:0]                                    ECHOED_CODE_O,
  output wch_pkg::wch_answer_t                          ANSWER_O,
  output logic                                          SENSOR_REQ_VALID_O,
  output wch_pkg::wch_query_t                           SENSOR_REQ_O
);

  // refuse decimals the table cannot serve
  if (DEC_MAX < 0 || DEC_MAX > wch_pkg::RECIP_COUNT - 1)
  begin : g_dec_check
    $error("DEC_MAX out of range");
  end

  localparam logic [2:0] DEC_LIMIT = 3'(DEC_MAX); // clamp for w_dec

  // handshake bookkeeping
  wch_pkg::wch_state_t    state_reg;    // handshake state
  logic                   qtb_last_reg; // query toggle seen last cycle
  logic                   qtb_cap_reg;  // toggle of the issued command
  logic [4:0]             code_reg;     // issued command code
  logic                   rep_reg;      // issued command repeats
  logic                   multi_reg;    // issued command has several replies

  // decoded helpers
  wch_pkg::wch_cmd_info_t info;         // decoded presented code
  logic [7:0]             unit_code;    // encoded unit of the reply
  logic [31:0]            weight_conv;  // converted weight
  logic [4:0]             free_len;     // used length of free text
  logic                   free_end;     // zero byte reached in free text
  logic                   trigger;      // new command presented
  logic                   do_send;      // command goes to the sensor
  logic                   do_local;     // command answered locally
  logic                   sent;         // sensor link took the request
  logic                   take_reply;   // reply belongs to current command
  logic                   first_reply;  // first reply after sending
  logic                   more;         // reply says more will follow
  logic                   keep_on;      // keep listening after this reply

  // code to command text
  wch_cmd_map u_cmd_map
  (
    .code_i (COMMAND_CODE_I),
    .info_o (info)
  );

  // unit string to unit byte
  wch_unit_enc u_unit_enc
  (
    .text_i (REPLY_I.unit_text),
    .code_o (unit_code)
  );

  // decimal weight to single float, mantissa truncated
  function automatic logic [31:0] to_float(input logic neg, input logic [31:0] mag,
                                           input logic [2:0] dec);
    logic [2:0]  d;
    logic [55:0] prod;
    logic [55:0] norm;
    logic [5:0]  lead;
    logic        any;
    logic [9:0]  bexp;
    d    = (dec > DEC_LIMIT) ? DEC_LIMIT : dec;
    prod = {24'h000000, mag} * {32'h00000000, wch_pkg::RECIP_MANT[d]};
    lead = 6'h00;
    any  = 1'b0;
    // find the leading one of the product
    for (int i = 0; i < 56; i++)
    begin
      if (prod[i])
      begin
        lead = 6'(i);
        any  = 1'b1;
      end
    end
    norm = prod << (6'd55 - lead);
    bexp = 10'(wch_pkg::FLT_BIAS + int'(lead) + wch_pkg::RECIP_EXP[d] - wch_pkg::FLT_MANT_W);
    return any ? {neg, bexp[7:0], norm[54:32]} : 32'h00000000;
  endfunction

  // weight, or zero when none
  assign weight_conv = REPLY_I.w_present ?
                       to_float(REPLY_I.w_neg, REPLY_I.w_mag, REPLY_I.w_dec) :
                       32'h00000000;

  // free string length up to first zero byte
  always_comb
  begin
    free_len = 5'h00;
    free_end = 1'b0;
    for (int k = wch_pkg::QUERY_BYTES - 1; k >= 0; k--)
    begin
      if (QUERY_TEXT_I[k] == 8'h00)
        free_end = 1'b1;
      else if (!free_end)
        free_len = free_len + 5'h01;
    end
  end

  // new command: toggle change while valid
  assign trigger  = QUERY_VALID_FLAG_I && (QUERY_TOGGLE_FLAG_I != qtb_last_reg);
  assign do_send  = trigger && (info.kind == wch_pkg::KIND_SEND ||
                                info.kind == wch_pkg::KIND_FREE);
  assign do_local = trigger && (info.kind == wch_pkg::KIND_LOCAL);
  // a reserved code matches neither and is dropped

  // request accepted; a newer command wins
  assign sent = (state_reg == wch_pkg::ST_SEND) && SENSOR_REQ_READY_I && !trigger;

  // replies only count while waiting or following
  assign take_reply  = REPLY_VALID_I && !trigger &&
                       (state_reg == wch_pkg::ST_WAIT || state_reg == wch_pkg::ST_FOLLOW);
  assign first_reply = take_reply && (state_reg == wch_pkg::ST_WAIT);
  assign more        = (REPLY_I.status == wch_pkg::STAT_MORE);
  assign keep_on     = rep_reg || (multi_reg && more);

  // query toggle history
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESET_N_I)
      qtb_last_reg <= wch_pkg::FLAG_RST;
    else
      qtb_last_reg <= QUERY_TOGGLE_FLAG_I;
  end

  // handshake state
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESET_N_I)
      state_reg <= wch_pkg::ST_IDLE;
    else if (do_send)
      state_reg <= wch_pkg::ST_SEND;
    else if (do_local)
      state_reg <= wch_pkg::ST_IDLE;
    else
    begin
      case (state_reg)
        wch_pkg::ST_IDLE: // nothing outstanding
          state_reg <= wch_pkg::ST_IDLE;
        wch_pkg::ST_SEND: // request waits for the link
          if (sent)
            state_reg <= wch_pkg::ST_WAIT;
        wch_pkg::ST_WAIT: // first reply decides what follows
          if (take_reply)
            state_reg <= keep_on ? wch_pkg::ST_FOLLOW : wch_pkg::ST_IDLE;
        wch_pkg::ST_FOLLOW: // repeats run until a new command
          if (take_reply && !keep_on)
            state_reg <= wch_pkg::ST_IDLE;
        default:
          state_reg <= wch_pkg::ST_IDLE;
      endcase
    end
  end

  // capture of the issued command
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESET_N_I)
    begin
      qtb_cap_reg <= wch_pkg::FLAG_RST;
      code_reg    <= wch_pkg::CODE_IDLE;
      rep_reg     <= 1'b0;
      multi_reg   <= 1'b0;
    end
    else if (do_send || do_local)
    begin
      qtb_cap_reg <= QUERY_TOGGLE_FLAG_I;
      code_reg    <= COMMAND_CODE_I;
      rep_reg     <= info.rep;
      multi_reg   <= info.multi;
    end
  end

  // request toward the sensor link
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESET_N_I)
    begin
      SENSOR_REQ_VALID_O <= 1'b0;
      SENSOR_REQ_O       <= '0;
    end
    else if (do_send)
    begin
      SENSOR_REQ_VALID_O <= 1'b1;
      if (info.kind == wch_pkg::KIND_FREE)
      begin
        SENSOR_REQ_O.text <= QUERY_TEXT_I;
        SENSOR_REQ_O.len  <= free_len;
      end
      else
      begin
        SENSOR_REQ_O.text <= {info.text, 192'h0};
        SENSOR_REQ_O.len  <= {2'b00, info.len};
      end
    end
    else if (sent || do_local)
      SENSOR_REQ_VALID_O <= 1'b0;
  end

  // response toggle and answer valid flags
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESET_N_I)
    begin
      RESPONSE_TOGGLE_FLAG_O <= wch_pkg::FLAG_RST;
      ANSWER_VALID_FLAG_O    <= wch_pkg::FLAG_RST;
    end
    else if (do_local)
    begin
      // local answer completes at once
      RESPONSE_TOGGLE_FLAG_O <= QUERY_TOGGLE_FLAG_I;
      ANSWER_VALID_FLAG_O    <= 1'b1;
    end
    else if (sent)
    begin
      // query gone out: copy toggle, withdraw old answer
      RESPONSE_TOGGLE_FLAG_O <= qtb_cap_reg;
      ANSWER_VALID_FLAG_O    <= 1'b0;
    end
    else if (first_reply)
      ANSWER_VALID_FLAG_O <= 1'b1;
  end

  // echoed code of the latest answer
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESET_N_I)
      ECHOED_CODE_O <= wch_pkg::CODE_IDLE;
    else if (do_local)
      ECHOED_CODE_O <= COMMAND_CODE_I;
    else if (take_reply)
      ECHOED_CODE_O <= code_reg;
  end

  // response image bytes 3..32
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESET_N_I)
      ANSWER_O <= '0;
    else if (do_local)
    begin
      // idle empty, batch not executable
      ANSWER_O <= '0;
      ANSWER_O.sensor_status_byte <= (COMMAND_CODE_I == wch_pkg::CODE_BATCH) ?
                                     wch_pkg::STAT_NOT_EXEC : wch_pkg::STAT_NONE;
    end
    else if (take_reply)
    begin
      // every reply overwrites the image
      if (code_reg == wch_pkg::CODE_FREE_TEXT)
      begin
        ANSWER_O.sensor_status_byte <= 8'h00;
        ANSWER_O.unit_code_byte     <= 8'h00;
        ANSWER_O.weight_float       <= 32'h00000000;
      end
      else
      begin
        ANSWER_O.sensor_status_byte <= REPLY_I.status;
        ANSWER_O.unit_code_byte     <= unit_code;
        ANSWER_O.weight_float       <= weight_conv;
      end
      ANSWER_O.raw <= EXT_MODE_I ? REPLY_I.raw : '0;
    end
  end

endmodule

// file: hdl/wch_pkg.sv
// constants and types of the weigh command handshake
package wch_pkg;

  // command codes presented by the controller
  localparam logic [4:0] CODE_IDLE           = 5'h00; // no function
  localparam logic [4:0] CODE_WEIGH_STABLE   = 5'h01; // stable weight
  localparam logic [4:0] CODE_WEIGH_NOW      = 5'h02; // immediate weight
  localparam logic [4:0] CODE_ZERO           = 5'h03; // zero
  localparam logic [4:0] CODE_ZERO_NOW       = 5'h04; // immediate zero
  localparam logic [4:0] CODE_SENSOR_RESET   = 5'h05; // sensor reset
  localparam logic [4:0] CODE_WEIGH_NOW_REP  = 5'h06; // weigh_now_repeat
  localparam logic [4:0] CODE_TARE           = 5'h07; // tare
  localparam logic [4:0] CODE_TARE_QUERY     = 5'h08; // tare value inquiry
  localparam logic [4:0] CODE_TARE_NOW       = 5'h09; // immediate tare
  localparam logic [4:0] CODE_TARE_CLEAR     = 5'h0A; // clear stored tare
  localparam logic [4:0] CODE_WEIGH_NEXT_REP = 5'h0B; // weigh_next_stable_repeat
  localparam logic [4:0] CODE_INT_ADJUST     = 5'h0C; // internal_adjust
  localparam logic [4:0] CODE_INT_CHECK      = 5'h0D; // internal_check
  localparam logic [4:0] CODE_BATCH          = 5'h0E; // not executable
  localparam logic [4:0] CODE_TRIG_WEIGH     = 5'h0F; // stable weight on trigger
  localparam logic [4:0] CODE_TRIG_ZERO      = 5'h10; // zero on trigger
  localparam logic [4:0] CODE_TRIG_QUERY     = 5'h11; // trigger mode inquiry
  localparam logic [4:0] CODE_TRIG_OFF       = 5'h12; // trigger mode off
  localparam logic [4:0] CODE_TRIG_ON        = 5'h13; // trigger mode on
  localparam logic [4:0] CODE_FORMAT_QUERY   = 5'h14; // output format inquiry
  localparam logic [4:0] CODE_CTRL_OFF       = 5'h15; // control mode off
  localparam logic [4:0] CODE_CTRL_ON        = 5'h16; // control mode on
  localparam logic [4:0] CODE_FREE_TEXT      = 5'h1F; // free-form string

  // status bytes
  localparam logic [7:0] STAT_NONE     = 8'h00; // locally answered idle
  localparam logic [7:0] STAT_NOT_EXEC = 8'h4C; // command not executable
  localparam logic [7:0] STAT_MORE     = 8'h42; // further replies follow

  // printable range for unit fallback
  localparam logic [7:0] CHAR_PRINT_LO = 8'h21;
  localparam logic [7:0] CHAR_PRINT_HI = 8'h7E;

  // field sizes
  localparam int QUERY_BYTES = 30; // bytes 3..32 of the query image
  localparam int RAW_BYTES   = 24; // bytes 9..32 of the response image
  localparam int CMD_BYTES   = 6;  // longest mapped command text
  localparam int UNIT_CHARS  = 4;  // longest unit string
  localparam int UNIT_COUNT  = 22; // entries of the unit table

  // reset value of the response flags
  localparam logic FLAG_RST = 1'b0;

  // single precision float layout
  localparam int FLT_BIAS   = 127;
  localparam int FLT_MANT_W = 23;

  // mantissas and exponents of ten to the minus d
  localparam int RECIP_COUNT = 7;
  localparam logic [23:0] RECIP_MANT [0:6] = '{24'h800000, 24'hCCCCCD,
    24'hA3D70A, 24'h83126F, 24'hD1B717, 24'hA7C5AC, 24'h8637BD};
  localparam int RECIP_EXP [0:6] = '{0, -4, -7, -10, -14, -17, -20};

  // handshake state, gray coded along the usual path
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SEND   = 2'b01,
    ST_WAIT   = 2'b11,
    ST_FOLLOW = 2'b10
  } wch_state_t;

  // how a command code is served
  typedef enum logic [1:0] {
    KIND_SEND  = 2'b00,
    KIND_LOCAL = 2'b01,
    KIND_RSVD  = 2'b10,
    KIND_FREE  = 2'b11
  } wch_kind_t;

  // decoded command, first char in the top byte
  typedef struct packed {
    logic [CMD_BYTES-1:0][7:0] text;
    logic [2:0]                len;
    wch_kind_t                 kind;
    logic                      rep;
    logic                      multi;
  } wch_cmd_info_t;

  // request toward the sensor link
  typedef struct packed {
    logic [QUERY_BYTES-1:0][7:0] text;
    logic [4:0]                  len;
  } wch_query_t;

  // parsed reply from the sensor link
  typedef struct packed {
    logic [7:0]                 status;
    logic [UNIT_CHARS-1:0][7:0] unit_text;
    logic                       w_present;
    logic                       w_neg;
    logic [31:0]                w_mag;
    logic [2:0]                 w_dec;
    logic [RAW_BYTES-1:0][7:0]  raw;
  } wch_reply_t;

  // response image bytes 3..32
  typedef struct packed {
    logic [7:0]                sensor_status_byte;
    logic [7:0]                unit_code_byte;
    logic [31:0]               weight_float;
    logic [RAW_BYTES-1:0][7:0] raw;
  } wch_answer_t;

endpackage

// file: hdl/wch_cmd_map.sv
// command code to sensor command text translation
`timescale 1ns/1ps
module wch_cmd_map
(
  input  wire logic [4:0]            code_i,
  output wch_pkg::wch_cmd_info_t     info_o
);

  // pack one table entry
  function automatic wch_pkg::wch_cmd_info_t mk(input logic [47:0] t, input logic [2:0] n,
                                                input wch_pkg::wch_kind_t k);
    wch_pkg::wch_cmd_info_t r;
    r.text  = t;
    r.len   = n;
    r.kind  = k;
    r.rep   = 1'b0;
    r.multi = 1'b0;
    return r;
  endfunction

  // text table; setting variants are never produced
  always_comb
  begin
    case (code_i)
      wch_pkg::CODE_IDLE:           info_o = mk(48'h000000000000, 3'd0, wch_pkg::KIND_LOCAL);
      wch_pkg::CODE_WEIGH_STABLE:   info_o = mk(48'h530000000000, 3'd1, wch_pkg::KIND_SEND);
      wch_pkg::CODE_WEIGH_NOW:      info_o = mk(48'h534900000000, 3'd2, wch_pkg::KIND_SEND);
      wch_pkg::CODE_ZERO:           info_o = mk(48'h5A0000000000, 3'd1, wch_pkg::KIND_SEND);
      wch_pkg::CODE_ZERO_NOW:       info_o = mk(48'h5A4900000000, 3'd2, wch_pkg::KIND_SEND);
      wch_pkg::CODE_SENSOR_RESET:   info_o = mk(48'h400000000000, 3'd1, wch_pkg::KIND_SEND);
      wch_pkg::CODE_WEIGH_NOW_REP:  info_o = mk(48'h534952000000, 3'd3, wch_pkg::KIND_SEND);
      wch_pkg::CODE_TARE:           info_o = mk(48'h540000000000, 3'd1, wch_pkg::KIND_SEND);
      wch_pkg::CODE_TARE_QUERY:     info_o = mk(48'h544100000000, 3'd2, wch_pkg::KIND_SEND);
      wch_pkg::CODE_TARE_NOW:       info_o = mk(48'h544900000000, 3'd2, wch_pkg::KIND_SEND);
      wch_pkg::CODE_TARE_CLEAR:     info_o = mk(48'h544143000000, 3'd3, wch_pkg::KIND_SEND);
      wch_pkg::CODE_WEIGH_NEXT_REP: info_o = mk(48'h534E52000000, 3'd3, wch_pkg::KIND_SEND);
      wch_pkg::CODE_INT_ADJUST:     info_o = mk(48'h433300000000, 3'd2, wch_pkg::KIND_SEND);
      wch_pkg::CODE_INT_CHECK:      info_o = mk(48'h545354330000, 3'd4, wch_pkg::KIND_SEND);
      wch_pkg::CODE_BATCH:          info_o = mk(48'h000000000000, 3'd0, wch_pkg::KIND_LOCAL);
      wch_pkg::CODE_TRIG_WEIGH:     info_o = mk(48'h545253000000, 3'd3, wch_pkg::KIND_SEND);
      wch_pkg::CODE_TRIG_ZERO:      info_o = mk(48'h54525A000000, 3'd3, wch_pkg::KIND_SEND);
      wch_pkg::CODE_TRIG_QUERY:     info_o = mk(48'h54524D4F0000, 3'd4, wch_pkg::KIND_SEND);
      wch_pkg::CODE_TRIG_OFF:       info_o = mk(48'h54524D4F2030, 3'd6, wch_pkg::KIND_SEND);
      wch_pkg::CODE_TRIG_ON:        info_o = mk(48'h54524D4F2031, 3'd6, wch_pkg::KIND_SEND);
      wch_pkg::CODE_FORMAT_QUERY:   info_o = mk(48'h4D4F44000000, 3'd3, wch_pkg::KIND_SEND);
      wch_pkg::CODE_CTRL_OFF:       info_o = mk(48'h4D4F44203000, 3'd5, wch_pkg::KIND_SEND);
      wch_pkg::CODE_CTRL_ON:        info_o = mk(48'h4D4F44203100, 3'd5, wch_pkg::KIND_SEND);
      wch_pkg::CODE_FREE_TEXT:      info_o = mk(48'h000000000000, 3'd0, wch_pkg::KIND_FREE);
      default:                      info_o = mk(48'h000000000000, 3'd0, wch_pkg::KIND_RSVD);
    endcase
    // repeating and multi-reply commands
    info_o.rep   = (code_i == wch_pkg::CODE_WEIGH_NOW_REP) ||
                   (code_i == wch_pkg::CODE_WEIGH_NEXT_REP);
    info_o.multi = (code_i == wch_pkg::CODE_INT_ADJUST) ||
                   (code_i == wch_pkg::CODE_INT_CHECK);
  end

endmodule

// file: hdl/wch_unit_enc.sv
// unit string to unit code byte encoder
`timescale 1ns/1ps
module wch_unit_enc
(
  input  wire logic [wch_pkg::UNIT_CHARS-1:0][7:0] text_i,
  output logic      [7:0]                          code_o
);

  // unit strings; the index is the unit code
  localparam logic [31:0] UNIT_STR [0:wch_pkg::UNIT_COUNT-1] = '{
    32'h00000000, 32'h67000000, 32'h6B670000, 32'h74000000, // none g kg t
    32'h6D670000, 32'hB5670000, 32'h63740000, 32'h4E000000, // mg ug ct N
    32'h6C620000, 32'h6F7A0000, 32'h6F7A7400, 32'h474E0000, // lb oz ozt GN
    32'h64777400, 32'h6D6F0000, 32'h6D736700, 32'h746C0000, // dwt mo msg tl
    32'h74636C00, 32'h746F6C61, 32'h62616874, 32'h50435300, // tcl tola baht PCS
    32'h25000000, 32'h23000000};                            // % #

  logic hit;   // table match found
  logic found; // printable fallback found

  // table lookup, else first printable character
  always_comb
  begin
    code_o = 8'h00;
    hit    = 1'b0;
    found  = 1'b0;
    for (int i = 0; i < wch_pkg::UNIT_COUNT; i++)
    begin
      if (text_i == UNIT_STR[i])
      begin
        hit    = 1'b1;
        code_o = 8'(i);
      end
    end
    if (!hit)
    begin
      // scan from the first character onward
      for (int j = wch_pkg::UNIT_CHARS - 1; j >= 0; j--)
      begin
        if (!found && text_i[j] >= wch_pkg::CHAR_PRINT_LO &&
            text_i[j] <= wch_pkg::CHAR_PRINT_HI)
        begin
          found  = 1'b1;
          code_o = text_i[j];
        end
      end
    end
  end

endmodule

// file: dv/wch_sensor_model.sv
// sensor link model
`timescale 1ns/1ps
module wch_sensor_model
(
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                req_valid_i,
  input  wire logic [2:0]          stall_i,
  input  wire logic [2:0]          n_i,
  input  wire logic                more_i,
  input  wire wch_pkg::wch_reply_t rep_i,
  output logic                     ready_o,
  output logic                     rep_valid_o,
  output wch_pkg::wch_reply_t      rep_o
);
  int cnt, left, gap; // stall, owed, gap
  // accept after stall, replies three cycles apart
  always_ff @(posedge clk_i)
  begin
    ready_o <= 1'b0;
    rep_valid_o <= 1'b0;
    rep_o <= ~rep_o; // junk between pulses
    if (!rst_n_i)
    begin
      rep_o <= '0;
      left <= 0;
      cnt <= 0;
    end
    else if (req_valid_i && ready_o)
    begin
      cnt <= 0;
      left <= n_i;
      gap <= 2;
    end
    else if (req_valid_i)
    begin
      ready_o <= (cnt >= stall_i);
      cnt <= cnt + 1;
    end
    else if (left > 0 && gap > 0)
      gap <= gap - 1;
    else if (left > 0)
    begin
      rep_valid_o <= 1'b1;
      rep_o <= rep_i;
      rep_o.status <= (more_i && left > 1) ? wch_pkg::STAT_MORE : rep_i.status;
      left <= left - 1;
      gap <= 2;
    end
  end
endmodule

// file: dv/wch_checker.sv
// assertions on the weigh command handshake ports
`timescale 1ns/1ps
module wch_checker
(
  input wire logic                 CLOCK_I,
  input wire logic                 RESET_N_I,
  input wire logic                 EXT_MODE_I,
  input wire logic                 QUERY_VALID_FLAG_I,
  input wire logic                 QUERY_TOGGLE_FLAG_I,
  input wire logic [4:0]           COMMAND_CODE_I,
  input wire logic                 SENSOR_REQ_READY_I,
  input wire logic                 REPLY_VALID_I,
  input wire logic                 RESPONSE_TOGGLE_FLAG_O,
  input wire logic                 ANSWER_VALID_FLAG_O,
  input wire logic [4:0]           ECHOED_CODE_O,
  input wire wch_pkg::wch_answer_t ANSWER_O,
  input wire logic                 SENSOR_REQ_VALID_O,
  input wire wch_pkg::wch_query_t  SENSOR_REQ_O
);
  logic tog_q; // last toggle
  logic trig;  // new command
  logic rsvd;  // reserved code
  logic loc;   // local answer code
  assign trig = QUERY_VALID_FLAG_I && (QUERY_TOGGLE_FLAG_I != tog_q);
  assign rsvd = (COMMAND_CODE_I >= 5'h17) && (COMMAND_CODE_I <= 5'h1E);
  assign loc  = (COMMAND_CODE_I == 5'h00) || (COMMAND_CODE_I == 5'h0E);
  // toggle history
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESET_N_I)
      tog_q <= 1'b0;
    else
      tog_q <= QUERY_TOGGLE_FLAG_I;
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);
  property p_issue; trig && !rsvd && !loc |=> SENSOR_REQ_VALID_O; endproperty
  a_issue: assert property (p_issue) else $error("no request");
  property p_idle; !trig && !SENSOR_REQ_VALID_O |=> !SENSOR_REQ_VALID_O; endproperty
  a_idle: assert property (p_idle) else $error("stray request");
  property p_rsvd; trig && rsvd && !SENSOR_REQ_VALID_O && !REPLY_VALID_I |=>
    $stable(RESPONSE_TOGGLE_FLAG_O) && $stable(ANSWER_VALID_FLAG_O) && !SENSOR_REQ_VALID_O;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved acted");
  property p_acc; SENSOR_REQ_VALID_O && SENSOR_REQ_READY_I && !trig |=> !SENSOR_REQ_VALID_O
    && !ANSWER_VALID_FLAG_O && RESPONSE_TOGGLE_FLAG_O == $past(QUERY_TOGGLE_FLAG_I);
  endproperty
  a_acc: assert property (p_acc) else $error("accept flags");
  property p_hold; SENSOR_REQ_VALID_O && !SENSOR_REQ_READY_I && !trig |=>
    SENSOR_REQ_VALID_O && $stable(SENSOR_REQ_O); endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_loc; trig && loc |=> ANSWER_VALID_FLAG_O && ECHOED_CODE_O == $past(COMMAND_CODE_I)
    && RESPONSE_TOGGLE_FLAG_O == $past(QUERY_TOGGLE_FLAG_I); endproperty
  a_loc: assert property (p_loc) else $error("local answer");
  property p_vrise; $rose(ANSWER_VALID_FLAG_O) |-> $past(REPLY_VALID_I) || $past(trig);
  endproperty
  a_vrise: assert property (p_vrise) else $error("valid without reply");
  property p_free; $rose(ANSWER_VALID_FLAG_O) && ECHOED_CODE_O == 5'h1F |->
    {ANSWER_O.sensor_status_byte, ANSWER_O.unit_code_byte, ANSWER_O.weight_float} == 48'h0;
  endproperty
  a_free: assert property (p_free) else $error("free text fields");
  property p_raw; $rose(ANSWER_VALID_FLAG_O) && !EXT_MODE_I |-> ANSWER_O.raw == '0; endproperty
  a_raw: assert property (p_raw) else $error("raw in basic");
endmodule
bind weigh_command_handshake wch_checker i_chk (.CLOCK_I, .RESET_N_I, .EXT_MODE_I,
  .QUERY_VALID_FLAG_I, .QUERY_TOGGLE_FLAG_I, .COMMAND_CODE_I, .SENSOR_REQ_READY_I,
  .REPLY_VALID_I, .RESPONSE_TOGGLE_FLAG_O, .ANSWER_VALID_FLAG_O, .ECHOED_CODE_O, .ANSWER_O,
  .SENSOR_REQ_VALID_O, .SENSOR_REQ_O);

// file: dv/tb_weigh_command_handshake.sv
// bench of the weigh command handshake
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_weigh_command_handshake;
  logic CLOCK_I = 1'b0, RESET_N_I = 1'b0, EXT_MODE_I = 1'b0, QUERY_VALID_FLAG_I = 1'b0;
  logic QUERY_TOGGLE_FLAG_I = 1'b0, SENSOR_REQ_READY_I, REPLY_VALID_I, SENSOR_REQ_VALID_O;
  logic RESPONSE_TOGGLE_FLAG_O, ANSWER_VALID_FLAG_O, more = 1'b0, r0;
  logic [4:0] COMMAND_CODE_I = 5'h00, ECHOED_CODE_O;
  logic [wch_pkg::QUERY_BYTES-1:0][7:0] QUERY_TEXT_I = '0;
  wch_pkg::wch_reply_t REPLY_I, rep = '0; // model reply
  wch_pkg::wch_answer_t ANSWER_O;
  wch_pkg::wch_query_t SENSOR_REQ_O;
  logic [2:0] stall = 3'h3, n = 3'h1; // model stall, replies
  int checks = 0, fail_count = 0;
  string cmap = "SSZZ@STTTTSCT-TTTTTMMM"; // first char per code
  always #5 CLOCK_I = ~CLOCK_I;
  weigh_command_handshake i_dut (.CLOCK_I, .RESET_N_I, .EXT_MODE_I, .QUERY_VALID_FLAG_I,
    .QUERY_TOGGLE_FLAG_I, .COMMAND_CODE_I, .QUERY_TEXT_I, .SENSOR_REQ_READY_I, .REPLY_VALID_I,
    .REPLY_I, .RESPONSE_TOGGLE_FLAG_O, .ANSWER_VALID_FLAG_O, .ECHOED_CODE_O, .ANSWER_O,
    .SENSOR_REQ_VALID_O, .SENSOR_REQ_O);
  wch_sensor_model i_sensor (.clk_i(CLOCK_I), .rst_n_i(RESET_N_I), .stall_i(stall), .n_i(n),
    .req_valid_i(SENSOR_REQ_VALID_O), .more_i(more), .rep_i(rep), .ready_o(SENSOR_REQ_READY_I),
    .rep_valid_o(REPLY_VALID_I), .rep_o(REPLY_I));
  // verdict
  task automatic give_verdict();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // new code, flipped toggle
  task automatic issue(input logic [4:0] c);
    @(negedge CLOCK_I);
    COMMAND_CODE_I = c;
    QUERY_TOGGLE_FLAG_I = ~QUERY_TOGGLE_FLAG_I;
  endtask
  // bounded wait for a valid answer
  task automatic await();
    int i = 0;
    while (!(ANSWER_VALID_FLAG_O === 1'b1 && RESPONSE_TOGGLE_FLAG_O === QUERY_TOGGLE_FLAG_I)
           && i < 60)
    begin
      @(negedge CLOCK_I);
      i++;
    end
    if (i == 60)
    begin
      fail_count++;
      give_verdict();
    end
  endtask
  initial
  begin
    rep.status = 8'h53;
    rep.unit_text = 32'h67000000;
    rep.w_present = 1'b1;
    rep.w_mag = 32'h0000007D;
    rep.w_dec = 3'h1;
    repeat (2) @(negedge CLOCK_I);
    RESET_N_I = 1'b1;
    @(negedge CLOCK_I);
    COMMAND_CODE_I = 5'h01;
    @(negedge CLOCK_I);
    QUERY_VALID_FLAG_I = 1'b1;
    QUERY_TOGGLE_FLAG_I = 1'b1;
    await();
    `CHK(RESPONSE_TOGGLE_FLAG_O, 1'b1)
    `CHK(ANSWER_O.weight_float, 32'h41480000)
    `CHK(ANSWER_O.unit_code_byte, 8'h01)
    `CHK(ANSWER_O.raw, 192'h0)
    stall = 3'h0;
    for (int c = 0; c < 23; c++)
    begin
      issue(c[4:0]);
      @(negedge CLOCK_I);
      if (c != 0 && c != 14) `CHK(SENSOR_REQ_O.text[29], cmap[c-1])
      await();
      `CHK(ECHOED_CODE_O, c[4:0])
      `CHK(ANSWER_O.sensor_status_byte, (c == 14) ? 8'h4C : (c == 0) ? 8'h00 : 8'h53)
    end
    r0 = QUERY_TOGGLE_FLAG_I;
    for (int c = 23; c < 31; c++)
    begin
      issue(c[4:0]);
      repeat (3) @(negedge CLOCK_I);
      `CHK(SENSOR_REQ_VALID_O, 1'b0)
      `CHK(RESPONSE_TOGGLE_FLAG_O, r0)
    end
    n = 3'h3;
    issue(5'h06);
    await();
    rep.unit_text = 32'h78797A00;
    rep.w_mag = 32'h0;
    repeat (8) @(negedge CLOCK_I);
    `CHK(ANSWER_O.unit_code_byte, 8'h78)
    `CHK(ANSWER_O.weight_float, 32'h0)
    more = 1'b1;
    n = 3'h2;
    rep.status = 8'h41;
    issue(5'h0C);
    await();
    `CHK(ANSWER_O.sensor_status_byte, 8'h42)
    repeat (5) @(negedge CLOCK_I);
    `CHK(ANSWER_O.sensor_status_byte, 8'h41)
    n = 3'h1;
    EXT_MODE_I = 1'b1;
    QUERY_TEXT_I[29] = 8'h41;
    rep.raw[23] = 8'h5A;
    issue(5'h1F);
    @(negedge CLOCK_I);
    `CHK(SENSOR_REQ_O.text[29], 8'h41)
    `CHK(SENSOR_REQ_O.len, 5'h01)
    await();
    `CHK(ANSWER_O.sensor_status_byte, 8'h00)
    `CHK(ANSWER_O.raw[23], 8'h5A)
    give_verdict();
  end
endmodule
